// [verilog/usb_hs_host_link.sv]
// High-speed downstream host link: framing, chirp handshake, SOF, suspend/resume
`timescale 1ns/1ns
module usb_hs_host_link #(
    parameter int CHIRP_CYC      = usb_hs_link_pkg::CHIRP_CYC,      // Chirp length
    parameter int SOF_FIRST_CYC  = usb_hs_link_pkg::SOF_FIRST_CYC,  // Chirp to SOF
    parameter int SOF_PERIOD_CYC = usb_hs_link_pkg::SOF_PERIOD_CYC  // Frame period
) (
    input  wire logic       clk_i,         // Bit clock
    input  wire logic       resetn_i,      // Async reset, active low
    input  wire logic       tx_valid_i,    // Packet bit offered
    output logic            tx_ready_o,    // Buffer has room
    input  wire logic       tx_bit_i,      // Raw packet bit
    input  wire logic       tx_last_i,     // Last bit of packet
    input  wire logic       tx_sof_i,      // Packet is a SOF
    input  wire logic       rx_active_i,   // Device is sending (pin)
    input  wire logic       dev_chirp_k_i, // Device chirp-K seen (pin)
    input  wire logic       port_reset_i,  // Firmware: bus reset
    input  wire logic       suspend_i,     // Firmware: suspend
    input  wire logic       resume_i,      // Firmware: resume signaling
    output logic [1:0]      line_o,        // Line state to drive
    output logic            line_oe_o,     // Host drives the line
    output logic            hs_mode_o,     // High-speed operation
    output logic            sof_due_o      // SOF packet wanted
);
    // ****************************************
    // Constants and types
    // ****************************************
    localparam int CHIRP_LAST = 2 * usb_hs_link_pkg::CHIRP_PAIRS - 1;
    typedef enum logic [2:0] {P_OFF, P_RESET, P_DEVK, P_CHIRP, P_FIRST, P_RUN,
                              P_SUSP, P_RESUME} port_e;
    typedef enum logic [1:0] {T_IDLE, T_SYNC, T_DATA, T_EOP} tx_e;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] rx_sync_reg, chk_sync_reg;
    logic       rx_act_s, dev_k_s;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_sync_reg  <= 2'h0;
            chk_sync_reg <= 2'h0;
        end else begin
            rx_sync_reg  <= {rx_sync_reg[0], rx_active_i};
            chk_sync_reg <= {chk_sync_reg[0], dev_chirp_k_i};
        end
    end
    assign rx_act_s = rx_sync_reg[1];
    assign dev_k_s  = chk_sync_reg[1];

    // ****************************************
    // Buffer and encoder
    // ****************************************
    bit_stream_if bs ();
    logic stuff, lvl_next, nz_init, nz_adv, nz_bit, nz_stuff_en;

    bit_buffer2 u_buf (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .in_valid_i (tx_valid_i),
        .in_ready_o (tx_ready_o),
        .in_data_i  ({tx_bit_i, tx_last_i, tx_sof_i}),
        .out        (bs.src)
    );

    nrzi_stuffer u_nrzi (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .init_i     (nz_init),
        .adv_i      (nz_adv),
        .bit_i      (nz_bit),
        .stuff_en_i (nz_stuff_en),
        .stuff_o    (stuff),
        .lvl_next_o (lvl_next)
    );

    // ****************************************
    // Port state: reset, chirp, SOF timing, suspend
    // ****************************************
    port_e       port_reg, port_next;
    tx_e         tx_reg, tx_next;
    logic [14:0] port_cnt_reg, port_cnt_next;
    logic [2:0]  chirp_idx_reg, chirp_idx_next;
    logic [13:0] sof_cnt_reg, sof_cnt_next;
    logic        sof_due_reg, sof_due_next;
    logic        sof_start;

    always_comb begin
        port_next      = port_reg;
        port_cnt_next  = port_cnt_reg + 15'h1;
        chirp_idx_next = chirp_idx_reg;
        sof_cnt_next   = 14'h0;
        sof_due_next   = 1'b0;
        unique case (port_reg)
            P_OFF: begin
                if (port_reset_i) begin
                    port_next = P_RESET;
                end
            end
            P_RESET: begin
                if (dev_k_s) begin
                    port_next = P_DEVK;
                end else if (!port_reset_i) begin
                    port_next = P_OFF;
                end
            end
            P_DEVK: begin
                // Answer at once: far inside the response window
                if (!dev_k_s) begin
                    port_next      = P_CHIRP;
                    port_cnt_next  = 15'h0;
                    chirp_idx_next = 3'h0;
                end
            end
            P_CHIRP: begin
                if (port_cnt_reg == 15'(CHIRP_CYC - 1)) begin
                    port_cnt_next  = 15'h0;
                    chirp_idx_next = chirp_idx_reg + 3'h1;
                    if (chirp_idx_reg == 3'(CHIRP_LAST)) begin
                        port_next = P_FIRST;
                    end
                end
            end
            P_FIRST: begin
                if (port_cnt_reg == 15'(SOF_FIRST_CYC - 1)) begin
                    port_next    = P_RUN;
                    sof_due_next = 1'b1;
                end
            end
            P_RUN: begin
                sof_due_next = sof_due_reg && !sof_start;
                sof_cnt_next = sof_cnt_reg + 14'h1;
                if (sof_cnt_reg == 14'(SOF_PERIOD_CYC - 1)) begin
                    sof_cnt_next = 14'h0;
                    sof_due_next = 1'b1;
                end
                if (suspend_i && tx_reg == T_IDLE) begin // A packet in flight ends first
                    port_next    = P_SUSP;
                    sof_due_next = 1'b0;
                end
            end
            P_SUSP: begin
                if (resume_i && !suspend_i) begin
                    port_next = P_RESUME;
                end
            end
            P_RESUME: begin
                // Bus goes idle when resume drops; first SOF follows at once
                if (!resume_i) begin
                    port_next    = P_RUN;
                    sof_due_next = 1'b1;
                end
            end
        endcase
        if (port_reset_i && port_reg != P_RESET && port_reg != P_DEVK) begin
            port_next    = P_RESET;
            sof_due_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_reg      <= P_OFF;
            port_cnt_reg  <= 15'h0;
            chirp_idx_reg <= 3'h0;
            sof_cnt_reg   <= 14'h0;
            sof_due_reg   <= 1'b0;
        end else begin
            port_reg      <= port_next;
            port_cnt_reg  <= port_cnt_next;
            chirp_idx_reg <= chirp_idx_next;
            sof_cnt_reg   <= sof_cnt_next;
            sof_due_reg   <= sof_due_next;
        end
    end

    // ****************************************
    // Packet framing
    // ****************************************
    logic [7:0] tx_cnt_reg, tx_cnt_next;
    logic [7:0] gap_reg, gap_next;
    logic       eop_sof_reg, eop_sof_next;

    // Gap counts idle symbols; line output lags state by one cycle
    assign sof_start = (tx_reg == T_IDLE) && (tx_next == T_SYNC) && bs.sof;

    always_comb begin
        tx_next      = tx_reg;
        tx_cnt_next  = tx_cnt_reg + 8'h1;
        eop_sof_next = eop_sof_reg;
        nz_init      = 1'b0;
        nz_adv       = 1'b0;
        nz_bit       = 1'b1;
        nz_stuff_en  = 1'b0;
        bs.ready     = 1'b0;
        unique case (tx_reg)
            T_IDLE: begin
                tx_cnt_next = 8'h0;
                if (port_reg == P_RUN && !suspend_i && bs.valid && !rx_act_s &&
                    gap_reg >= 8'(usb_hs_link_pkg::IPG_MIN - 1)) begin
                    tx_next      = T_SYNC;
                    eop_sof_next = bs.sof;
                    nz_init      = 1'b1;
                end
            end
            T_SYNC: begin
                nz_adv = 1'b1;
                nz_bit = (tx_cnt_reg == 8'(usb_hs_link_pkg::SYNC_BITS - 1));
                if (nz_bit) begin
                    tx_next = T_DATA;
                end
            end
            T_DATA: begin
                nz_stuff_en = 1'b1;
                nz_bit      = bs.data;
                nz_adv      = bs.valid || stuff;
                bs.ready    = !stuff;
                tx_cnt_next = 8'h0;
                // Source underrun aborts the packet with its end pattern
                if (!bs.valid && !stuff) begin
                    tx_next = T_EOP;
                end else if (!stuff && bs.last) begin
                    tx_next = T_EOP;
                end
            end
            T_EOP: begin
                // First end symbol is a raw zero, so the line always toggles
                nz_adv = 1'b1;
                nz_bit = (tx_cnt_reg != 8'h0);
                if (tx_cnt_reg == (eop_sof_reg ? 8'(usb_hs_link_pkg::SOF_EOP_BITS - 1)
                                               : 8'(usb_hs_link_pkg::EOP_BITS - 1))) begin
                    tx_next = T_IDLE;
                end
            end
        endcase
        if (rx_act_s || tx_reg != T_IDLE) begin
            gap_next = 8'h0;
        end else begin
            gap_next = (gap_reg == 8'hff) ? gap_reg : gap_reg + 8'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_reg      <= T_IDLE;
            tx_cnt_reg  <= 8'h0;
            gap_reg     <= 8'hff;
            eop_sof_reg <= 1'b0;
        end else begin
            tx_reg      <= tx_next;
            tx_cnt_reg  <= tx_cnt_next;
            gap_reg     <= gap_next;
            eop_sof_reg <= eop_sof_next;
        end
    end

    // ****************************************
    // Line drive
    // ****************************************
    logic [1:0] line_reg, line_next;
    logic       oe_reg, oe_next, hs_reg, hs_next;

    always_comb begin
        line_next = line_reg;
        oe_next   = 1'b0;
        hs_next   = (port_next == P_FIRST) || (port_next == P_RUN);
        unique case (port_next)
            P_RESET: begin
                line_next = usb_hs_link_pkg::LINE_SE0;
                oe_next   = 1'b1;
            end
            P_CHIRP: begin
                line_next = chirp_idx_next[0] ? usb_hs_link_pkg::LINE_J
                                              : usb_hs_link_pkg::LINE_K;
                oe_next   = 1'b1;
            end
            P_RESUME: begin
                line_next = usb_hs_link_pkg::LINE_K;
                oe_next   = 1'b1;
            end
            P_FIRST, P_RUN: begin
                oe_next = 1'b1;
                if (tx_reg == T_IDLE) begin
                    line_next = usb_hs_link_pkg::LINE_SE0;
                end else if (nz_adv) begin
                    line_next = lvl_next ? usb_hs_link_pkg::LINE_J
                                         : usb_hs_link_pkg::LINE_K;
                end
            end
            default: begin
                line_next = usb_hs_link_pkg::LINE_SE0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_reg <= usb_hs_link_pkg::LINE_SE0;
            oe_reg   <= 1'b0;
            hs_reg   <= 1'b0;
        end else begin
            line_reg <= line_next;
            oe_reg   <= oe_next;
            hs_reg   <= hs_next;
        end
    end

    assign line_o    = line_reg;
    assign line_oe_o = oe_reg;
    assign hs_mode_o = hs_reg;
    assign sof_due_o = sof_due_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence chirp_done_s;
        port_reg == P_CHIRP ##1 port_reg == P_FIRST;
    endsequence

    sync_len_a: assert property (tx_reg == T_SYNC && tx_next != T_SYNC |->
        tx_cnt_reg == 8'(usb_hs_link_pkg::SYNC_BITS - 1) && tx_next == T_DATA)
        else $error("sync field length wrong");
    gap_min_a: assert property ($rose(tx_reg == T_SYNC) |->
        $past(gap_reg) >= 8'(usb_hs_link_pkg::IPG_MIN - 1) && !$past(rx_act_s))
        else $error("inter-packet gap too short");
    eop_len_a: assert property (tx_reg == T_EOP ##1 tx_reg == T_IDLE |->
        $past(tx_cnt_reg) == ($past(eop_sof_reg) ? 8'(usb_hs_link_pkg::SOF_EOP_BITS - 1)
                                                 : 8'(usb_hs_link_pkg::EOP_BITS - 1)))
        else $error("end pattern length wrong");
    eop_toggle_a: assert property (tx_reg == T_EOP && tx_cnt_reg == 8'h0 &&
        port_reg == P_RUN |=> line_o != $past(line_o))
        else $error("end pattern does not start with a transition");
    chirp_resp_a: assert property (port_reg == P_DEVK && !dev_k_s |=>
        port_reg == P_CHIRP && line_o == usb_hs_link_pkg::LINE_K && line_oe_o)
        else $error("host chirp not started");
    chirp_dur_a: assert property (port_reg == P_CHIRP &&
        chirp_idx_next != chirp_idx_reg |-> port_cnt_reg == 15'(CHIRP_CYC - 1))
        else $error("chirp length wrong");
    chirp_pairs_a: assert property (chirp_done_s |->
        $past(chirp_idx_reg) == 3'(CHIRP_LAST))
        else $error("too few chirp pairs");
    first_sof_a: assert property (port_reg == P_FIRST ##1 port_reg == P_RUN |->
        $past(port_cnt_reg) == 15'(SOF_FIRST_CYC - 1) && sof_due_o)
        else $error("first frame start mistimed");
    sof_period_a: assert property (port_reg == P_RUN && !suspend_i && !port_reset_i &&
        sof_cnt_reg == 14'(SOF_PERIOD_CYC - 1) |=> sof_due_o && sof_cnt_reg == 14'h0)
        else $error("frame start not raised");
    susp_quiet_a: assert property (port_reg == P_SUSP |->
        !sof_due_o && tx_reg == T_IDLE && !line_oe_o)
        else $error("activity during suspend");
    resume_sof_a: assert property (port_reg == P_RESUME && !resume_i && !port_reset_i |=>
        port_reg == P_RUN && sof_due_o)
        else $error("frame start not resumed");
endmodule

// [verilog/usb_hs_link_pkg.sv]
// Shared constants and types for the high-speed host link timing block
package usb_hs_link_pkg;
    // ****************************************
    // Clock and framing, one clk cycle per bit time
    // ****************************************
    localparam int CLK_MHZ      = 100;
    localparam int SYNC_BITS    = 32;
    localparam int IPG_MIN      = 8;
    localparam int IPG_MAX      = 192;
    localparam int EOP_BITS     = 8;
    localparam int SOF_EOP_BITS = 40;
    localparam int CHIRP_PAIRS  = 3;
    localparam int STUFF_RUN    = 6;
    // ****************************************
    // Port timing in microseconds and derived cycles
    // ****************************************
    localparam int CHIRP_RESP_US    = 100;
    localparam int CHIRP_MIN_US     = 40;
    localparam int CHIRP_MAX_US     = 60;
    localparam int SOF_FIRST_MIN_US = 100;
    localparam int SOF_FIRST_MAX_US = 500;
    localparam int SOF_PERIOD_US    = 125;
    localparam int RESUME_SOF_US    = 3000;
    localparam int CHIRP_CYC     = (CHIRP_MIN_US + CHIRP_MAX_US) / 2 * CLK_MHZ;
    localparam int SOF_FIRST_CYC = (SOF_FIRST_MIN_US + SOF_FIRST_MAX_US) / 2 * CLK_MHZ;
    localparam int SOF_PERIOD_CYC = SOF_PERIOD_US * CLK_MHZ;
    // Buffer word: {bit, last, sof}
    localparam int WORD_W = 3;

    typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K} line_e;
endpackage

// [verilog/bit_stream_if.sv]
// Bit stream carrier between the buffer and the framing engine
`timescale 1ns/1ns
interface bit_stream_if;
    logic valid;
    logic ready;
    logic data;
    logic last;
    logic sof;
    modport src (output valid, output data, output last, output sof, input ready);
    modport snk (input valid, input data, input last, input sof, output ready);
endinterface

// [verilog/bit_buffer2.sv]
// Two-entry buffer between the packet source and the framing engine
`timescale 1ns/1ns
module bit_buffer2 (
    input  wire logic                              clk_i,      // Clock
    input  wire logic                              resetn_i,   // Async reset
    input  wire logic                              in_valid_i, // Word offered
    output logic                                   in_ready_o, // Room free
    input  wire logic [usb_hs_link_pkg::WORD_W-1:0] in_data_i,  // {bit,last,sof}
    bit_stream_if.src                              out         // Drain side
);
    logic [usb_hs_link_pkg::WORD_W-1:0] mem_reg [2];
    logic [usb_hs_link_pkg::WORD_W-1:0] mem_next [2];
    logic [1:0] cnt_reg, cnt_next;
    logic       wr_reg, wr_next, rd_reg, rd_next;
    logic       push, pop;

    assign in_ready_o = (cnt_reg != 2'h2);
    assign out.valid  = (cnt_reg != 2'h0);
    assign {out.data, out.last, out.sof} = mem_reg[rd_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out.valid && out.ready;

    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        if (push) begin
            mem_next[wr_reg] = in_data_i;
            wr_next          = ~wr_reg;
        end
        if (pop) begin
            rd_next = ~rd_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            cnt_reg    <= 2'h0;
            wr_reg     <= 1'b0;
            rd_reg     <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
        end
    end
endmodule

// [verilog/nrzi_stuffer.sv]
// NRZI encoder with bit stuffing that can be switched off
`timescale 1ns/1ns
module nrzi_stuffer (
    input  wire logic clk_i,      // Clock
    input  wire logic resetn_i,   // Async reset
    input  wire logic init_i,     // Return to J, clear run
    input  wire logic adv_i,      // Emit one symbol
    input  wire logic bit_i,      // Raw bit
    input  wire logic stuff_en_i, // Stuffing allowed
    output logic      stuff_o,    // This symbol is a stuffed zero
    output logic      lvl_next_o  // Emitted level, 1 = J
);
    logic       lvl_reg;
    logic [2:0] ones_reg, ones_next;
    logic       eff;

    assign stuff_o = stuff_en_i && (ones_reg == 3'(usb_hs_link_pkg::STUFF_RUN));
    assign eff     = stuff_o ? 1'b0 : bit_i;

    always_comb begin
        lvl_next_o = lvl_reg;
        ones_next  = ones_reg;
        if (init_i) begin
            lvl_next_o = 1'b1;
            ones_next  = 3'h0;
        end else if (adv_i) begin
            lvl_next_o = eff ? lvl_reg : ~lvl_reg;
            ones_next  = eff ? ((ones_reg == 3'h7) ? ones_reg : ones_reg + 3'h1) : 3'h0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lvl_reg  <= 1'b1;
            ones_reg <= 3'h0;
        end else begin
            lvl_reg  <= lvl_next_o;
            ones_reg <= ones_next;
        end
    end
endmodule

// [tb/usb_dev_model.sv]
// Behavioural attached high-speed device on the downstream port
`timescale 1ns/1ns
module usb_dev_model (
    input  wire logic clk_i,      // Bit clock
    input  wire logic hs_mode_i,  // Host left chirp phase
    output logic      chirp_k_o,  // Device chirp-K pin
    output logic      rx_active_o // Device transmitting pin
);
    logic hs_term = 1'b0;
    initial begin
        chirp_k_o = 1'b0;
        rx_active_o = 1'b0;
    end
    // Terminations swap once the host chirps end
    // Falls again in suspend: full-speed pull-up back on the line
    always @(posedge clk_i) hs_term <= hs_mode_i;
    task automatic chirp(input int n);
        @(negedge clk_i);
        chirp_k_o = 1'b1;
        repeat (n) @(negedge clk_i);
        chirp_k_o = 1'b0;
    endtask
    task automatic talk(input int n);
        rx_active_o = 1'b1;
        repeat (n) @(negedge clk_i);
        rx_active_o = 1'b0;
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the high-speed host link
`timescale 1ns/1ns
module tb;
    localparam int CC = 20;
    localparam int FC = 40;
    localparam int PC = 800;
    logic         clk_i = 1'b0, resetn_i = 1'b0, tx_valid_i = 1'b0, tx_bit_i = 1'b0;
    logic         tx_last_i = 1'b0, tx_sof_i = 1'b0, port_reset_i = 1'b0;
    logic         suspend_i = 1'b0, resume_i = 1'b0, mon = 1'b1;
    logic         tx_ready_o, line_oe_o, hs_mode_o, sof_due_o, dev_k, rx_act;
    logic [1:0]   line_o, prev = 2'h1, last = 2'h0;
    logic [127:0] cur_v = '0, ev;
    logic [127:0] exp_v[$];
    int           exp_n[$];
    int           mismatches = 0, total_checks = 0, cur_n = 0, gap = 0, pgap = 0;
    int           rl = 0, nrun = 0, t;
    time          t0;
    usb_hs_host_link #(.CHIRP_CYC(CC), .SOF_FIRST_CYC(FC), .SOF_PERIOD_CYC(PC)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_bit_i(tx_bit_i), .tx_last_i(tx_last_i),
        .tx_sof_i(tx_sof_i), .rx_active_i(rx_act), .dev_chirp_k_i(dev_k),
        .port_reset_i(port_reset_i), .suspend_i(suspend_i), .resume_i(resume_i),
        .line_o(line_o), .line_oe_o(line_oe_o), .hs_mode_o(hs_mode_o), .sof_due_o(sof_due_o));
    usb_dev_model dev (.clk_i(clk_i), .hs_mode_i(hs_mode_o), .chirp_k_o(dev_k),
        .rx_active_o(rx_act));
    initial forever #5 clk_i = ~clk_i;
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string m);
        chk_eq(32'(got >= lo && got <= hi), 32'h1, m);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(inout int n);
        @(negedge clk_i);
        n++;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((exp_n.size() != 0 || cur_n != 0) && n < 1000) tick(n);
        chk_rng(n, 0, 999, "packet drain");
    endtask
    // Every fourth bit zero keeps runs short, so no stuffed symbol is expected
    task automatic send(input int n, input logic sof);
        logic [127:0] v;
        logic         b;
        v = 128'h1;
        for (int i = 0; i < n; i++) begin
            b = (i % 4 == 3) ? 1'b0 : 1'($urandom);
            v = {v[126:0], b};
            tx_valid_i = 1'b1;
            tx_bit_i = b;
            tx_last_i = (i == n - 1);
            tx_sof_i = sof;
            while (tx_ready_o !== 1'b1) @(negedge clk_i);
            @(negedge clk_i);
        end
        tx_valid_i = 1'b0;
        tx_last_i = 1'b0;
        v = {v[126:0], 1'b0};
        for (int i = 1; i < (sof ? 40 : 8); i++) v = {v[126:0], 1'b1};
        exp_v.push_back(v);
        exp_n.push_back(32 + n + (sof ? 40 : 8));
        @(negedge clk_i);
    endtask
    // ****************************************
    // Line monitor: chirp runs, NRZI decode, gaps
    // ****************************************
    always @(negedge clk_i) begin
        if (mon && line_oe_o === 1'b1 && hs_mode_o === 1'b0 && line_o !== 2'h0) begin
            if (line_o !== last && rl != 0) begin
                chk_eq(rl, CC, "chirp length");
                rl = 0;
            end
            if (line_o !== last) nrun++;
            rl++;
            last = line_o;
        end else if (mon && line_oe_o === 1'b1 && line_o !== 2'h0) begin
            if (cur_n == 0) pgap = gap;
            gap = 0;
            cur_v = {cur_v[126:0], line_o === prev};
            cur_n++;
            prev = line_o;
        end else begin
            if (cur_n > 0) begin
                ev = exp_v.size() > 0 ? exp_v.pop_front() : '1;
                chk_eq(cur_n, exp_n.size() > 0 ? exp_n.pop_front() : 0, "length");
                chk_eq(32'(cur_v === ev), 32'h1, "packet symbols");
                cur_v = '0;
                cur_n = 0;
                prev = 2'h1;
            end
            gap = (rx_act === 1'b1) ? 0 : gap + 1;
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        $display("[FAIL] %0t watchdog expired", $time);
        mismatches++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h9e51acde));
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        @(negedge clk_i);
        chk_eq({line_o, line_oe_o, hs_mode_o, sof_due_o, tx_ready_o}, 6'h01, "reset values");
        port_reset_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk_eq({line_oe_o, line_o}, 3'h4, "bus reset drive");
        fork
            begin
                repeat (12) @(negedge clk_i);
                port_reset_i = 1'b0;
            end
        join_none
        dev.chirp(30);
        t = 0;
        while (line_o !== 2'h2 && t < 10001) tick(t);
        chk_rng(t, 1, 10000, "chirp response");
        t = 0;
        while (hs_mode_o !== 1'b1 && t < 500) tick(t);
        chk_rng(t, 0, 499, "high-speed entry");
        chk_eq(nrun, 6, "chirp count");
        chk_eq(rl, CC, "final chirp");
        t = 0;
        while (sof_due_o !== 1'b1 && t < 500) tick(t);
        chk_rng(t, FC - 2, FC + 2, "first frame delay");
        t0 = $time;
        send(24, 1'b1);
        send(24, 1'b0);
        send(32, 1'b0);
        drain();
        chk_rng(pgap, 8, 192, "back to back gap");
        dev.talk(40);
        send(8, 1'b0);
        drain();
        chk_rng(pgap, 8, 192, "reply gap");
        t = 0;
        while (sof_due_o !== 1'b1 && t < PC) tick(t);
        chk_eq(32'(($time - t0) / 10), PC, "frame period");
        send(24, 1'b1);
        drain();
        suspend_i = 1'b1;
        repeat (3) @(negedge clk_i);
        fork
            send(16, 1'b0);
        join_none
        nrun = 0;
        repeat (2 * PC) begin
            @(negedge clk_i);
            nrun += int'(sof_due_o !== 1'b0 || line_oe_o !== 1'b0);
        end
        chk_eq(nrun, 0, "suspend silence");
        chk_eq(tx_ready_o, 1'b0, "buffer full");
        chk_eq(dev.hs_term, 1'b0, "device back to full speed");
        mon = 1'b0;
        suspend_i = 1'b0;
        resume_i = 1'b1;
        repeat (20) @(negedge clk_i);
        chk_eq({line_oe_o, line_o}, 3'h6, "resume drive");
        resume_i = 1'b0;
        t = 0;
        while (sof_due_o !== 1'b1 && t < 300) tick(t);
        chk_rng(t, 0, 2, "frame restart");
        mon = 1'b1;
        wait fork;
        drain();
        finish_test();
    end
endmodule
